// ---- hdl/pll_phase_align_control.sv ----
// Phase alignment control: sync events, feedback fold factor, seed phase shift.
`default_nettype none
module pll_phase_align_control
    import pll_align_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic sync_pin,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic vco_cal_done,
    input wire logic loop_settled,
    input wire vco_cal_s vco_cal_result,
    output logic vco_cal_start,
    output logic sync_event,
    output logic vco_force_enable,
    output vco_cal_s vco_force_value,
    output logic [3:0] feedback_folded_factor,
    output logic chan_div_power,
    output logic modulator_hold,
    output logic phase_aligned,
    output logic [35:0] phase_shift_num,
    output logic [41:0] phase_shift_den
);
    // ----------------------------------------------------------------
    // Channel divider decoding
    // ----------------------------------------------------------------
    function automatic logic [9:0] div_value(input logic [4:0] idx);
        logic [9:0] v;
        v = 10'h000;
        case (idx)
            5'h00: v = 10'h002;
            5'h01: v = 10'h004;
            5'h02: v = 10'h006;
            5'h03: v = 10'h008;
            5'h04: v = 10'h00c;
            5'h05: v = 10'h010;
            5'h06: v = 10'h018;
            5'h07: v = 10'h020;
            5'h08: v = 10'h030;
            5'h09: v = 10'h040;
            5'h0a: v = 10'h048;
            5'h0b: v = 10'h060;
            5'h0c: v = 10'h080;
            5'h0d: v = 10'h0c0;
            5'h0e: v = 10'h100;
            5'h0f: v = 10'h180;
            5'h10: v = 10'h200;
            5'h11: v = 10'h300;
            default: v = 10'h000;
        endcase
        return v;
    endfunction

    align_state_s s_ff;
    align_state_s nxt_s;
    logic [1:0] mux_a;
    logic [1:0] mux_b;
    logic [9:0] div_total;
    logic chan_routed;
    logic pin_rise;
    logic pin_event;
    logic sw_sync;
    logic sync_now;
    logic cal_en;
    logic [2:0] order;
    logic seed_ok;
    logic seed_mult;
    logic [3:0] factor;

    assign cal_en = s_ff.ctrl[CTRL_CAL_EN];
    assign order = s_ff.ctrl[CTRL_ORDER_LSB +: 3];
    assign mux_a = s_ff.outsel[OUTSEL_A_LSB +: 2];
    assign mux_b = s_ff.outsel[OUTSEL_B_LSB +: 2];
    assign div_total = div_value(s_ff.outsel[OUTSEL_DIV_LSB +: 5]);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        // The pin is asynchronous: two stages settle it and the third keeps the last level.
        nxt_s.pin_sync = {s_ff.pin_sync[1:0], sync_pin};
        nxt_s.sync_event = 1'b0;
        nxt_s.cal_start = 1'b0;
        nxt_s.rdata = '0;
        sw_sync = 1'b0;
        // Edge seen on the second stage against its own history only.
        pin_rise = s_ff.pin_sync[1] & ~s_ff.pin_sync[2];
        pin_event = pin_rise & cal_en & ~s_ff.ctrl[CTRL_PIN_MASK];
        // A zero denominator is never a multiple, so order one then refuses every seed.
        seed_mult = (s_ff.den != 32'h0) && ((reg_wdata % s_ff.den) == 32'h0);
        seed_ok = (order != 3'h0) && ((order != 3'h1) || seed_mult);
        if (reg_write) begin
            case (reg_addr)
                REG_CTRL: begin
                    // The very first write only programs; it never syncs.
                    sw_sync = s_ff.programmed & ~s_ff.ctrl[CTRL_ALIGN]
                        & reg_wdata[CTRL_ALIGN];
                    nxt_s.ctrl = reg_wdata;
                    nxt_s.programmed = 1'b1;
                end
                REG_OUTSEL: nxt_s.outsel = reg_wdata;
                REG_FRAC_NUMERATOR_VALUE: nxt_s.num = reg_wdata;
                REG_FRAC_DEN: nxt_s.den = reg_wdata;
                REG_SEED: begin
                    if (seed_ok) begin
                        nxt_s.seed_accum = s_ff.seed_accum + reg_wdata;
                    end
                end
                REG_MOD_RST_CNT: nxt_s.rst_cnt = reg_wdata;
                REG_VCO_FORCE: begin
                    nxt_s.force_en = reg_wdata[VCO_FORCE_BIT];
                    nxt_s.force_val.core = reg_wdata[2:0];
                    nxt_s.force_val.cap = reg_wdata[VCO_CAP_LSB +: 8];
                    nxt_s.force_val.bias = reg_wdata[VCO_BIAS_LSB +: 9];
                end
                default: begin
                end
            endcase
        end
        sync_now = sw_sync | pin_event;
        // A restart of the phase origin wins over a seed add in the same cycle.
        if (sync_now || !s_ff.ctrl[CTRL_MOD_RSTN]) begin
            nxt_s.seed_accum = '0;
        end
        nxt_s.sync_event = sync_now;
        nxt_s.cal_start = sync_now & cal_en;

        // Idle and aligned leave only on a sync event, which is handled after this case.
        unique case (s_ff.phase)
            PH_IDLE: begin
            end
            PH_ALIGNED: begin
            end
            PH_CAL: begin
                if (vco_cal_done) begin
                    nxt_s.phase = PH_SETTLE;
                end
            end
            PH_SETTLE: begin
                if (loop_settled) begin
                    if (s_ff.ctrl[CTRL_FRAC_MODE] && s_ff.rst_cnt != 32'h0) begin
                        nxt_s.phase = PH_MODRST;
                        nxt_s.wait_cnt = s_ff.rst_cnt - 32'h1;
                    end else begin
                        nxt_s.phase = PH_ALIGNED;
                    end
                end
            end
            PH_MODRST: begin
                if (s_ff.wait_cnt == 32'h0) begin
                    nxt_s.phase = PH_ALIGNED;
                end else begin
                    nxt_s.wait_cnt = s_ff.wait_cnt - 32'h1;
                end
            end
        endcase
        if (sync_now) begin
            nxt_s.phase = cal_en ? PH_CAL : PH_SETTLE;
            nxt_s.wait_cnt = '0;
        end

        // The divider also runs for the reference path on output B, even when A bypasses it.
        chan_routed = (mux_a == MUX_CHAN_DIV_VALUE) || (mux_b == MUX_CHAN_DIV_VALUE)
            || (mux_b == MUX_SYSREF);
        nxt_s.chan_power = chan_routed;
        // An invalid divider index decodes to zero and must not count as divisible by three.
        if (!s_ff.ctrl[CTRL_ALIGN] || !chan_routed) begin
            factor = FACTOR_ONE;
        end else if (div_total == DIV_TWO) begin
            factor = FACTOR_FOUR;
        end else if ((div_total % 10'h003) == 10'h000 && div_total != 10'h000
            && div_total != DIV_EXCL_LOW && div_total != DIV_EXCL_HIGH) begin
            factor = FACTOR_SIX;
        end else begin
            factor = FACTOR_FOUR;
        end
        nxt_s.factor = factor;
        // Phase in degrees is 360 * phase_num / phase_den.
        nxt_s.phase_num = 36'(s_ff.seed_accum) * 36'(s_ff.factor);
        nxt_s.phase_den = 42'(s_ff.den) * 42'(div_total);

        // Read data stand for one cycle only; an idle bus reads as zero.
        if (reg_read) begin
            case (reg_addr)
                REG_CTRL: nxt_s.rdata = s_ff.ctrl;
                REG_OUTSEL: nxt_s.rdata = s_ff.outsel;
                REG_FRAC_NUMERATOR_VALUE: nxt_s.rdata = s_ff.num;
                REG_FRAC_DEN: nxt_s.rdata = s_ff.den;
                REG_SEED: nxt_s.rdata = s_ff.seed_accum;
                REG_MOD_RST_CNT: nxt_s.rdata = s_ff.rst_cnt;
                REG_STATUS: begin
                    nxt_s.rdata[3:0] = s_ff.factor;
                    nxt_s.rdata[STAT_CHAN_PWR] = s_ff.chan_power;
                    nxt_s.rdata[STAT_ALIGNED] = (s_ff.phase == PH_ALIGNED);
                    nxt_s.rdata[STAT_BUSY] = (s_ff.phase != PH_ALIGNED)
                        && (s_ff.phase != PH_IDLE);
                end
                REG_VCO_READ: begin
                    nxt_s.rdata[2:0] = vco_cal_result.core;
                    nxt_s.rdata[VCO_CAP_LSB +: 8] = vco_cal_result.cap;
                    nxt_s.rdata[VCO_BIAS_LSB +: 9] = vco_cal_result.bias;
                end
                REG_VCO_FORCE: begin
                    nxt_s.rdata[VCO_FORCE_BIT] = s_ff.force_en;
                    nxt_s.rdata[2:0] = s_ff.force_val.core;
                    nxt_s.rdata[VCO_CAP_LSB +: 8] = s_ff.force_val.cap;
                    nxt_s.rdata[VCO_BIAS_LSB +: 9] = s_ff.force_val.bias;
                end
                default: nxt_s.rdata = '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            // Reset leaves both outputs on the VCO, so the divider starts unpowered.
            s_ff <= '0;
            s_ff.ctrl <= CTRL_RESET;
            s_ff.outsel <= OUTSEL_RESET;
            s_ff.den <= DEN_RESET;
            s_ff.factor <= FACTOR_ONE;
            s_ff.phase <= PH_IDLE;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Every output comes from the state register; the two status levels decode it.
    assign reg_rdata = s_ff.rdata;
    assign vco_cal_start = s_ff.cal_start;
    assign sync_event = s_ff.sync_event;
    assign vco_force_enable = s_ff.force_en;
    assign vco_force_value = s_ff.force_val;
    assign feedback_folded_factor = s_ff.factor;
    assign chan_div_power = s_ff.chan_power;
    assign modulator_hold = ~s_ff.ctrl[CTRL_MOD_RSTN] || (s_ff.phase == PH_MODRST);
    assign phase_aligned = (s_ff.phase == PH_ALIGNED);
    assign phase_shift_num = s_ff.phase_num;
    assign phase_shift_den = s_ff.phase_den;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    pin_retime_a: assert property (
        $rose(s_ff.pin_sync[1]) && cal_en && !s_ff.ctrl[CTRL_PIN_MASK] && !reg_write
        |=> sync_event && vco_cal_start)
        else $error("pin edge not turned into a sync event");
    pin_ignored_a: assert property (
        !$past(cal_en) |-> !vco_cal_start)
        else $error("calibration started while calibration disabled");
    factor_one_a: assert property (
        !s_ff.ctrl[CTRL_ALIGN] || !chan_routed |=> feedback_folded_factor == FACTOR_ONE)
        else $error("fold factor not one");
    factor_div_a: assert property (
        s_ff.ctrl[CTRL_ALIGN] && chan_routed && s_ff.outsel[OUTSEL_DIV_LSB +: 5] == 5'h04
        |=> feedback_folded_factor == FACTOR_SIX)
        else $error("fold factor not six for division twelve");
    sw_sync_a: assert property (
        reg_write && reg_addr == REG_CTRL && s_ff.programmed && !s_ff.ctrl[CTRL_ALIGN]
        && reg_wdata[CTRL_ALIGN] |=> sync_event ##1 (!sync_event || $past(pin_event)))
        else $error("software sync pulse wrong");
    first_write_a: assert property (
        reg_write && reg_addr == REG_CTRL && !s_ff.programmed && !pin_event
        |=> !sync_event)
        else $error("initial programming raised a sync event");
    seed_clear_a: assert property (
        sync_event |-> s_ff.seed_accum == 32'h0)
        else $error("seed phase not cleared on sync");
    seed_add_a: assert property (
        reg_write && reg_addr == REG_SEED && seed_ok && !sync_now
        && s_ff.ctrl[CTRL_MOD_RSTN] |=> s_ff.seed_accum == $past(s_ff.seed_accum)
        + $past(reg_wdata))
        else $error("seed write did not accumulate");
    chan_power_a: assert property (
        mux_b == MUX_SYSREF |=> chan_div_power)
        else $error("divider unpowered with reference selected");
    aligned_wait_a: assert property (
        sync_event && vco_cal_start |-> !phase_aligned [*2])
        else $error("aligned too soon after sync");
    sync_unaligned_a: assert property (
        sync_event |-> !phase_aligned)
        else $error("aligned in the cycle of a sync");
    factor_four_a: assert property (
        s_ff.ctrl[CTRL_ALIGN] && chan_routed && s_ff.outsel[OUTSEL_DIV_LSB +: 5] == 5'h00
        |=> feedback_folded_factor == FACTOR_FOUR)
        else $error("fold factor not four for division two");
    factor_excl_a: assert property (
        s_ff.ctrl[CTRL_ALIGN] && chan_routed && (div_total == DIV_EXCL_LOW
        || div_total == DIV_EXCL_HIGH) |=> feedback_folded_factor == FACTOR_FOUR)
        else $error("fold factor not four for an excluded division");
    pin_off_a: assert property (
        !cal_en && !(reg_write && reg_addr == REG_CTRL) |=> !sync_event)
        else $error("sync pin acted while calibration disabled");
    cal_start_a: assert property (
        vco_cal_start |-> sync_event)
        else $error("calibration started without a sync event");
    seed_refused_a: assert property (
        reg_write && reg_addr == REG_SEED && !seed_ok && !sync_now
        && s_ff.ctrl[CTRL_MOD_RSTN] |=> $stable(s_ff.seed_accum))
        else $error("refused seed write changed the phase");
    mod_reset_a: assert property (
        !s_ff.ctrl[CTRL_MOD_RSTN] |=> s_ff.seed_accum == 32'h0)
        else $error("seed phase kept while modulator held in reset");
    force_bit_a: assert property (
        reg_write && reg_addr == REG_VCO_FORCE
        |=> vco_force_enable == $past(reg_wdata[VCO_FORCE_BIT]))
        else $error("force enable not taken from the write");
    phase_den_a: assert property (
        1'b1 |=> phase_shift_den == 42'($past(s_ff.den)) * 42'($past(div_total)))
        else $error("phase ratio denominator wrong");
endmodule
`default_nettype wire

// ---- common/pll_align_pkg.sv ----
// Shared constants, register map and types for the phase alignment control block.
`default_nettype none
package pll_align_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_OUTSEL = 8'h04;
    localparam logic [7:0] REG_FRAC_NUMERATOR_VALUE = 8'h08;
    localparam logic [7:0] REG_FRAC_DEN = 8'h0c;
    localparam logic [7:0] REG_SEED = 8'h10;
    localparam logic [7:0] REG_MOD_RST_CNT = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_VCO_READ = 8'h1c;
    localparam logic [7:0] REG_VCO_FORCE = 8'h20;
    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_ALIGN = 0;
    localparam int CTRL_CAL_EN = 1;
    localparam int CTRL_PIN_MASK = 2;
    localparam int CTRL_FRAC_MODE = 3;
    localparam int CTRL_MOD_RSTN = 4;
    localparam int CTRL_ORDER_LSB = 5;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0014;
    localparam int OUTSEL_A_LSB = 0;
    localparam int OUTSEL_B_LSB = 2;
    localparam int OUTSEL_DIV_LSB = 4;
    localparam logic [31:0] OUTSEL_RESET = 32'h0000_0005;
    localparam logic [31:0] DEN_RESET = 32'h0000_0001;
    localparam int VCO_CAP_LSB = 3;
    localparam int VCO_BIAS_LSB = 11;
    localparam int VCO_FORCE_BIT = 20;
    localparam int STAT_CHAN_PWR = 4;
    localparam int STAT_ALIGNED = 5;
    localparam int STAT_BUSY = 6;
    // ----------------------------------------------------------------
    // Output selection codes and fold factors
    // ----------------------------------------------------------------
    localparam logic [1:0] MUX_CHAN_DIV_VALUE = 2'h0;
    localparam logic [1:0] MUX_VCO = 2'h1;
    localparam logic [1:0] MUX_SYSREF = 2'h2;
    localparam logic [3:0] FACTOR_ONE = 4'h1;
    localparam logic [3:0] FACTOR_FOUR = 4'h4;
    localparam logic [3:0] FACTOR_SIX = 4'h6;
    localparam logic [9:0] DIV_EXCL_LOW = 10'h018;
    localparam logic [9:0] DIV_EXCL_HIGH = 10'h0c0;
    localparam logic [9:0] DIV_TWO = 10'h002;
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {PH_IDLE, PH_CAL, PH_SETTLE, PH_MODRST, PH_ALIGNED} phase_e;
    typedef struct packed {
        logic [2:0] core;
        logic [7:0] cap;
        logic [8:0] bias;
    } vco_cal_s;
    typedef struct packed {
        logic [2:0] pin_sync;
        logic programmed;
        logic [31:0] ctrl;
        logic [31:0] outsel;
        logic [31:0] num;
        logic [31:0] den;
        logic [31:0] seed_accum;
        logic [31:0] rst_cnt;
        logic force_en;
        vco_cal_s force_val;
        phase_e phase;
        logic [31:0] wait_cnt;
        logic sync_event;
        logic cal_start;
        logic [3:0] factor;
        logic chan_power;
        logic [35:0] phase_num;
        logic [41:0] phase_den;
        logic [31:0] rdata;
    } align_state_s;
endpackage
`default_nettype wire

// ---- verif/pll_align_partner.sv ----
// Far-side model: calibration engine, loop monitor and board logic on the sync pin.
`default_nettype none
module pll_align_partner
    import pll_align_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic pin_level,
    input wire logic [7:0] cal_delay,
    input wire logic vco_cal_start,
    output logic sync_pin,
    output logic vco_cal_done,
    output logic loop_settled,
    output vco_cal_s vco_cal_result
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cal_cnt_ff = 8'h00;
    logic [2:0] run_ff = 3'h0;
    logic pin_ff = 1'b0;
    // The pin moves on the falling edge, well away from the reference rising edges.
    always @(negedge clock) begin
        pin_ff <= pin_level;
    end
    assign sync_pin = pin_ff;
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cal_cnt_ff <= 8'h00;
            run_ff <= 3'h0;
        end else if (vco_cal_start) begin
            cal_cnt_ff <= cal_delay;
            run_ff <= run_ff + 3'h1;
        end else if (cal_cnt_ff != 8'h00) begin
            cal_cnt_ff <= cal_cnt_ff - 8'h01;
        end
    end
    assign vco_cal_done = (cal_cnt_ff == 8'h01);
    assign loop_settled = (cal_cnt_ff == 8'h00);
    // Each calibration lands on a new code, the codes repeating after eight, as a real engine may.
    assign vco_cal_result = '{core: run_ff, cap: {run_ff, 5'h15}, bias: {run_ff, 6'h2a}};
endmodule
`default_nettype wire

// ---- verif/pll_phase_align_control_tb.sv ----
// Self-checking bench for the phase alignment control block.
`default_nettype none
module pll_phase_align_control_tb
    import pll_align_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic pin_level = 1'b0;
    logic sync_pin, vco_cal_done, loop_settled, vco_cal_start, sync_event, vco_force_enable;
    logic chan_div_power, modulator_hold, phase_aligned;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic [DATA_W-1:0] reg_rdata;
    logic [3:0] feedback_folded_factor;
    logic [35:0] phase_shift_num;
    logic [41:0] phase_shift_den;
    vco_cal_s vco_cal_result, vco_force_value;
    logic [7:0] cal_delay = 8'h05;
    integer seed = 32'h232aefaa;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    localparam int DIVS [18] = '{2, 4, 6, 8, 12, 16, 24, 32, 48, 64, 72, 96, 128, 192, 256,
        384, 512, 768};
    localparam logic [9:0] CORNER [6] = '{{1'b1, MUX_VCO, MUX_SYSREF, 5'd0},
        {1'b1, MUX_CHAN_DIV_VALUE, MUX_VCO, 5'd6}, {1'b1, MUX_CHAN_DIV_VALUE, MUX_VCO, 5'd13},
        {1'b1, MUX_VCO, MUX_VCO, 5'd2}, {1'b1, MUX_CHAN_DIV_VALUE, MUX_VCO, 5'd4},
        {1'b1, MUX_CHAN_DIV_VALUE, MUX_VCO, 5'd20}};

    pll_phase_align_control i_dut (
        .clock(clock), .resetn(resetn), .sync_pin(sync_pin), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .vco_cal_done(vco_cal_done), .loop_settled(loop_settled),
        .vco_cal_result(vco_cal_result), .vco_cal_start(vco_cal_start),
        .sync_event(sync_event), .vco_force_enable(vco_force_enable),
        .vco_force_value(vco_force_value), .feedback_folded_factor(feedback_folded_factor),
        .chan_div_power(chan_div_power), .modulator_hold(modulator_hold),
        .phase_aligned(phase_aligned), .phase_shift_num(phase_shift_num),
        .phase_shift_den(phase_shift_den)
    );
    pll_align_partner i_partner (
        .clock(clock), .resetn(resetn), .pin_level(pin_level), .cal_delay(cal_delay),
        .vco_cal_start(vco_cal_start), .sync_pin(sync_pin), .vco_cal_done(vco_cal_done),
        .loop_settled(loop_settled), .vco_cal_result(vco_cal_result)
    );

    always #20 clock = ~clock;

    // ----------------------------------------------------------------
    // Tasks and expectations
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask
    // Raises the pin and reports after how many edges a sync pulse shows.
    task automatic pin_try(output int n, output logic cs);
        n = 0;
        cs = 1'b0;
        @(posedge clock);
        pin_level <= 1'b1;
        for (int i = 1; i <= 8; i++) begin
            @(posedge clock);
            #1;
            if (sync_event === 1'b1 && n == 0) begin
                n = i;
                cs = vco_cal_start;
            end
        end
        @(posedge clock);
        pin_level <= 1'b0;
        tick(4);
    endtask
    task automatic align_wait(output int n, output logic hold_seen);
        n = 0;
        hold_seen = 1'b0;
        while (phase_aligned !== 1'b1 && n < 60) begin
            tick(1);
            n++;
            if (modulator_hold === 1'b1) hold_seen = 1'b1;
        end
    endtask
    function automatic logic [3:0] exp_factor(input logic al, input logic [1:0] a, b,
        input int tot);
        if (!al || (a != MUX_CHAN_DIV_VALUE && b != MUX_CHAN_DIV_VALUE && b != MUX_SYSREF)) return FACTOR_ONE;
        if (tot != 0 && tot % 3 == 0 && tot != 24 && tot != 192) return FACTOR_SIX;
        return FACTOR_FOUR;
    endfunction

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            end_of_test();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        int n;
        logic hs, cs, al;
        logic [1:0] a, b;
        logic [4:0] idx;
        logic [31:0] fv;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        rd_chk(REG_CTRL, CTRL_RESET);
        rd_chk(REG_OUTSEL, OUTSEL_RESET);
        rd_chk(REG_FRAC_DEN, DEN_RESET);
        rd_chk(8'h40, 32'h0);
        check(feedback_folded_factor, FACTOR_ONE);
        check(chan_div_power, 1'b0);
        wr(REG_CTRL, 32'h0000_005b);
        check(sync_event, 1'b0);
        wr(REG_FRAC_DEN, 32'd12);
        wr(REG_FRAC_NUMERATOR_VALUE, 32'd8 / FACTOR_FOUR);
        rd_chk(REG_FRAC_NUMERATOR_VALUE, 32'd2);
        for (int k = 0; k < 24; k++) begin
            a = 2'($unsigned($random(seed)) % 3);
            b = 2'($unsigned($random(seed)) % 3);
            idx = 5'($unsigned($random(seed)) % 18);
            al = 1'($random(seed));
            if (k < 6) {al, a, b, idx} = CORNER[k];
            wr(REG_CTRL, {24'h0, 5'h0b, ~al, 1'b1, al});
            wr(REG_OUTSEL, {23'h0, idx, b, a});
            tick(2);
            check(feedback_folded_factor, exp_factor(al, a, b, idx < 18 ? DIVS[idx] : 0));
            check(chan_div_power, a == MUX_CHAN_DIV_VALUE || b != MUX_VCO);
        end
        wr(REG_CTRL, 32'h0000_005b);
        wr(REG_OUTSEL, 32'h0000_0054);
        wr(REG_SEED, 32'd1);
        wr(REG_SEED, 32'd2);
        rd_chk(REG_SEED, 32'd3);
        tick(3);
        check(phase_shift_num, 36'd12);
        check(phase_shift_den, 42'd192);
        wr(REG_CTRL, 32'h0000_003b);
        wr(REG_SEED, 32'd5);
        rd_chk(REG_SEED, 32'd3);
        wr(REG_CTRL, 32'h0000_001b);
        wr(REG_SEED, 32'd1);
        rd_chk(REG_SEED, 32'd3);
        wr(REG_CTRL, 32'h0000_000b);
        rd_chk(REG_SEED, 32'd0);
        wr(REG_CTRL, 32'h0000_005b);
        wr(REG_SEED, 32'd4);
        wr(REG_MOD_RST_CNT, 32'd3);
        wr(REG_CTRL, 32'h0000_005e);
        wr(REG_CTRL, 32'h0000_005b);
        check(sync_event, 1'b1);
        check(vco_cal_start, 1'b1);
        align_wait(n, hs);
        check(n >= 8 && n < 40, 1'b1);
        check(hs, 1'b1);
        rd_chk(REG_STATUS, 32'h0000_0034);
        rd_chk(REG_SEED, 32'd0);
        wr(REG_CTRL, 32'h0000_0056);
        wr(REG_CTRL, 32'h0000_0053);
        check(sync_event, 1'b1);
        align_wait(n, hs);
        check(n >= 5 && n < 40, 1'b1);
        check(hs, 1'b0);
        pin_try(n, cs);
        check(n, 3);
        check(cs, 1'b1);
        wr(REG_CTRL, 32'h0000_0051);
        pin_try(n, cs);
        check(n, 0);
        wr(REG_CTRL, 32'h0000_0057);
        pin_try(n, cs);
        check(n, 0);
        fv = {12'h0, 9'($random(seed)), 8'($random(seed)), 3'($random(seed))};
        rd_chk(REG_VCO_READ, {12'h0, vco_cal_result.bias, vco_cal_result.cap,
            vco_cal_result.core});
        wr(REG_VCO_FORCE, fv | 32'h0010_0000);
        check(vco_force_enable, 1'b1);
        check(vco_force_value, {fv[2:0], fv[10:3], fv[19:11]});
        @(posedge clock);
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        rd_chk(REG_CTRL, CTRL_RESET);
        check(feedback_folded_factor, FACTOR_ONE);
        wr(REG_CTRL, 32'h0000_005b);
        check(sync_event, 1'b0);
        end_of_test();
    end
endmodule
`default_nettype wire
